// *** common/srl_pkg.sv ***
package srl_pkg;

  // ---------------------------------------------------------------------
  // Clock and base tick
  // ---------------------------------------------------------------------
  localparam int SRL_CLK_HZ = 20_000_000;
  localparam int SRL_TICK_MS = 1;
  localparam int SRL_TICK_CYC = SRL_CLK_HZ / 1000 * SRL_TICK_MS;

  // ---------------------------------------------------------------------
  // Intervals in milliseconds
  // ---------------------------------------------------------------------
  localparam logic [11:0] SRL_HALF_MS = 12'h1F4;
  localparam logic [11:0] SRL_PAUSE_MS = 12'h7D0;
  localparam logic [11:0] SRL_SETTLE_MS = 12'h064;
  localparam logic [11:0] SRL_BLIP_MS = 12'h096;
  localparam logic [11:0] SRL_RST_MIN_MS = 12'h0FA;
  localparam logic [11:0] SRL_RST_MAX_MS = 12'hBB8;
  localparam logic [18:0] SRL_CFG_TIMEOUT_MS = 19'h493E0;
  localparam logic [3:0] SRL_TP_PERIOD_MS = 4'hC;

  // ---------------------------------------------------------------------
  // Switch positions
  // ---------------------------------------------------------------------
  localparam logic [3:0] SRL_POS_CFG = 4'h0;
  localparam logic [3:0] SRL_POS_MM = 4'h1;
  localparam logic [3:0] SRL_POS_AM = 4'h2;
  localparam logic [3:0] SRL_POS_MM_MAX = 4'h4;
  localparam logic [3:0] SRL_POS_LOGIC_MAX = 4'h8;
  localparam logic [3:0] SRL_POS_OFF_MAX = 4'h4;
  localparam logic [3:0] SRL_POS_ON_MAX = 4'h7;
  localparam logic [3:0] SRL_POS_JOG_MAX = 4'h9;
  localparam logic [3:0] SRL_TIME_LONG = 4'hA;

  typedef enum logic [1:0] {
    SRL_VAR_SINGLE = 2'h0,
    SRL_VAR_DUAL = 2'h1,
    SRL_VAR_TIMING = 2'h2
  } srl_var_t;

  typedef enum logic [5:0] {
    SRL_ST_BOOT = 6'h01,
    SRL_ST_CHECK = 6'h02,
    SRL_ST_CFG_WAIT = 6'h04,
    SRL_ST_CFG = 6'h08,
    SRL_ST_RUN = 6'h10,
    SRL_ST_FAULT = 6'h20
  } srl_state_t;

  // Range maximum divided by ten, in ms; times the time position gives ms
  function automatic logic [19:0] srl_range_unit(input logic [3:0] pos,
                                                 input logic long_r);
    logic [19:0] u;
    u = 20'h00000;
    case (pos)
      4'h1: u = long_r ? 20'h02710 : 20'h00064;
      4'h2: u = long_r ? 20'h186A0 : 20'h003E8;
      4'h3: u = long_r ? 20'h493E0 : 20'h00BB8;
      4'h4: u = 20'h07530;
      4'h5: u = long_r ? 20'h07530 : 20'h0012C;
      4'h6: u = long_r ? 20'h493E0 : 20'h00BB8;
      4'h7: u = 20'h07530;
      4'h8: u = long_r ? 20'h186A0 : 20'h003E8;
      4'h9: u = long_r ? 20'h493E0 : 20'h00BB8;
      default: u = 20'h00000;
    endcase
    return u;
  endfunction

endpackage

// *** hw/srl_flasher.sv ***
`timescale 1ns/1ps
module srl_flasher
  import srl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ms_tick,
  input wire logic enable,
  input wire logic [3:0] count,
  output logic led_q
);

  typedef struct packed {
    logic [11:0] cnt;
    logic [3:0] n;
    logic led;
    logic pause;
  } srl_fl_t;

  srl_fl_t q;
  srl_fl_t d;

  // ---------------------------------------------------------------------
  // Burst of counted flashes, then a pause
  // ---------------------------------------------------------------------
  always_comb begin
    d = q;
    if (!enable) begin
      d = '0;
      d.pause = 1'b1;
    end else if (ms_tick) begin
      d.cnt = q.cnt + 12'h001;
      if (q.pause) begin
        if (q.cnt == SRL_PAUSE_MS - 12'h001) begin
          d.cnt = '0;
          d.n = '0;
          d.pause = (count == 4'h0);
          d.led = (count != 4'h0);
        end
      end else if (q.cnt == SRL_HALF_MS - 12'h001) begin
        d.cnt = '0;
        if (q.led) begin
          d.led = 1'b0;
          d.n = q.n + 4'h1;
          d.pause = (q.n + 4'h1 >= count);
        end else begin
          d.led = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{cnt: 12'h000, n: 4'h0, led: 1'b0, pause: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign led_q = q.led;

endmodule

// *** hw/srl_top.sv ***
`timescale 1ns/1ps
module srl_top
  import srl_pkg::*;
#(
  parameter int MS_CYCLES = SRL_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] variant,
  input wire logic [3:0] reset_sw,
  input wire logic [3:0] logic_sw,
  input wire logic [3:0] range_sw,
  input wire logic [3:0] time_sw,
  input wire logic timing_config_terminal_a_to_b,
  input wire logic timing_config_terminal_a_to_24v,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic link_safety_input,
  input wire logic reset_monitor_input,
  input wire logic circuit_check_ok,
  input wire logic nvm_valid,
  input wire logic [3:0] nvm_cfg_pos,
  input wire logic [3:0] nvm_time_pos,
  input wire logic nvm_long_range,
  output logic safety_out_q,
  output logic power_fault_red_q,
  output logic power_fault_green_q,
  output logic ind_input_a_q,
  output logic ind_cfg_term_q,
  output logic ind_link_q,
  output logic test_pulse_q,
  output logic nvm_erase_q,
  output logic nvm_write_q,
  output logic [3:0] nvm_wr_cfg_q,
  output logic [3:0] nvm_wr_time_q,
  output logic nvm_wr_long_q,
  output logic config_mode_q,
  output logic perm_fault_q
);

  localparam int PW = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    srl_state_t st;
    logic [PW-1:0] pre;
    logic tick;
    logic [1:0] var_s;
    logic [11:0] tmr;
    logic ph;
    logic [11:0] blip;
    logic [18:0] to;
    logic [3:0] cfg;
    logic [3:0] tim_pos;
    logic long_r;
    logic [3:0] tp_cnt;
    logic tp;
    logic b_seen;
    logic out;
    logic rst_prev;
    logic [11:0] rst_len;
    logic tim_run;
    logic [23:0] tim;
    logic red;
    logic green;
    logic ind_a;
    logic ind_t;
    logic ind_l;
    logic erase;
    logic write;
    logic fault;
    logic cfgm;
  } srl_top_t;

  srl_top_t q;
  srl_top_t d;

  // ---------------------------------------------------------------------
  // Decode of switches and inputs
  // ---------------------------------------------------------------------
  logic is_timing;
  logic is_dual;
  logic [3:0] cur_cfg;
  logic [3:0] lg;
  logic pair;
  logic en;
  logic mm;
  logic fn_off;
  logic fn_on;
  logic fn_jog;
  logic retrig;
  logic cfg_bad;
  logic [23:0] delay;
  logic [2:0] fl_en;
  logic [2:0] fl_led;
  logic [3:0] fl_cnt [3];

  assign is_timing = (q.var_s == SRL_VAR_TIMING);
  assign is_dual = (q.var_s == SRL_VAR_DUAL);
  assign cur_cfg = is_timing ? range_sw : (is_dual ? logic_sw : reset_sw);

  assign lg = q.cfg - 4'h1;
  assign pair = lg[0] ? (safety_input_a & safety_input_b)
                      : (safety_input_a | safety_input_b);
  always_comb begin
    if (is_timing) begin
      en = link_safety_input;
    end else if (is_dual) begin
      en = lg[1] ? (pair & link_safety_input) : (pair | link_safety_input);
    end else begin
      // Second channel required only if b_seen; the reset after configuration clears it, so run requires input A alone
      en = q.b_seen ? (safety_input_a & safety_input_b) : safety_input_a;
    end
  end

  assign mm = is_dual ? (q.cfg <= SRL_POS_MM_MAX) : (q.cfg == SRL_POS_MM);
  assign fn_off = (q.cfg <= SRL_POS_OFF_MAX);
  assign fn_on = (q.cfg > SRL_POS_OFF_MAX) && (q.cfg <= SRL_POS_ON_MAX);
  assign fn_jog = (q.cfg > SRL_POS_ON_MAX);
  assign retrig = timing_config_terminal_a_to_b & fn_off;
  assign delay = 24'(srl_range_unit(q.cfg, q.long_r) * q.tim_pos);

  always_comb begin
    if (is_timing) begin
      cfg_bad = (cur_cfg > SRL_POS_JOG_MAX) || (time_sw == 4'h0) ||
                (time_sw > SRL_TIME_LONG);
    end else if (is_dual) begin
      cfg_bad = (cur_cfg > SRL_POS_LOGIC_MAX);
    end else begin
      cfg_bad = (cur_cfg > SRL_POS_AM);
    end
  end

  // ---------------------------------------------------------------------
  // Setting report flashers
  // ---------------------------------------------------------------------
  always_comb begin
    fl_en[0] = (q.st == SRL_ST_CFG) && !is_timing;
    fl_en[1] = (q.st == SRL_ST_CFG) && is_timing;
    fl_en[2] = (q.st == SRL_ST_CFG) && is_timing;
    fl_cnt[0] = cur_cfg;
    fl_cnt[1] = cur_cfg;
    fl_cnt[2] = time_sw;
  end

  for (genvar i = 0; i < 3; i++) begin : g_fl
    srl_flasher u_fl (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ms_tick(q.tick),
      .enable(fl_en[i]),
      .count(fl_cnt[i]),
      .led_q(fl_led[i])
    );
  end

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_comb begin
    d = q;
    d.erase = 1'b0;
    d.write = 1'b0;
    d.tick = 1'b0;
    if (q.pre == PW'(MS_CYCLES - 1)) begin
      d.pre = '0;
      d.tick = 1'b1;
    end else begin
      d.pre = q.pre + PW'(1);
    end
    if (q.tick) begin
      d.tmr = q.tmr + 12'h001;
      if (q.tmr == SRL_HALF_MS - 12'h001) begin
        d.tmr = '0;
        d.ph = ~q.ph;
      end
    end

    case (q.st)
      SRL_ST_BOOT: begin
        d.var_s = variant;
        d.st = SRL_ST_CHECK;
      end

      SRL_ST_CHECK: begin
        d.cfg = cur_cfg;
        d.tim_pos = time_sw;
        d.tmr = '0;
        if (cur_cfg == SRL_POS_CFG) begin
          d.long_r = (time_sw == SRL_TIME_LONG);
          d.erase = 1'b1;
          d.st = SRL_ST_CFG_WAIT;
        end else begin
          d.long_r = nvm_long_range;
          if (!nvm_valid || cfg_bad || !circuit_check_ok ||
              (cur_cfg != nvm_cfg_pos) ||
              (is_timing && (time_sw != nvm_time_pos))) begin
            d.st = SRL_ST_FAULT;
          end else begin
            d.st = SRL_ST_RUN;
          end
        end
      end

      SRL_ST_CFG_WAIT: begin
        if (q.tick && (q.tmr == SRL_SETTLE_MS)) begin
          d.tmr = '0;
          d.ph = 1'b1;
          d.to = '0;
          d.st = SRL_ST_CFG;
        end
      end

      SRL_ST_CFG: begin
        if (q.tick) begin
          d.tp_cnt = (q.tp_cnt == SRL_TP_PERIOD_MS - 4'h1) ? 4'h0 : q.tp_cnt + 4'h1;
          d.to = q.to + 19'h00001;
          if (q.blip != 12'h000) begin
            d.blip = q.blip - 12'h001;
          end
        end
        d.tp = q.tick && (q.tp_cnt == 4'h0);
        if (q.tp && safety_input_b) begin
          d.b_seen = 1'b1;
        end
        if ((cur_cfg != q.cfg) || (time_sw != q.tim_pos)) begin
          d.cfg = cur_cfg;
          d.tim_pos = time_sw;
          d.write = 1'b1;
          d.blip = SRL_BLIP_MS;
          d.to = '0;
        end
        d.red = q.ph || (q.blip != 12'h000);
        d.ind_a = fl_led[0];
        d.ind_t = fl_led[1];
        d.ind_l = fl_led[2];
        // Operator left it too long without the closing power cycle
        if (q.to == SRL_CFG_TIMEOUT_MS) begin
          d.tp = 1'b0;
          d.ind_a = 1'b0;
          d.ind_t = 1'b0;
          d.ind_l = 1'b0;
          d.st = SRL_ST_FAULT;
        end
      end

      SRL_ST_RUN: begin
        d.green = 1'b1;
        d.red = 1'b0;
        d.ind_a = safety_input_a;
        d.ind_t = is_timing & retrig;
        d.ind_l = link_safety_input;
        d.rst_prev = reset_monitor_input;
        if (is_timing) begin
          if (!fn_off) begin
            if (!en || (fn_jog && !timing_config_terminal_a_to_24v)) begin
              d.out = 1'b0;
              d.tim = '0;
            end else begin
              if (q.tick && (q.tim < delay)) begin
                d.tim = q.tim + 24'h000001;
              end
              d.out = fn_on ? (q.tim >= delay) : (q.tim < delay);
            end
          end else if (q.tim_run) begin
            if (retrig && en) begin
              d.tim_run = 1'b0;
              d.tim = '0;
            end else if (q.tim >= delay) begin
              d.out = 1'b0;
              d.tim_run = 1'b0;
              d.tim = '0;
            end else if (q.tick) begin
              d.tim = q.tim + 24'h000001;
            end
          end else if (q.out && !en) begin
            d.tim_run = 1'b1;
          end else if (!q.out && en) begin
            d.out = 1'b1;
          end
        end else begin
          if (reset_monitor_input) begin
            if (q.tick && (q.rst_len <= SRL_RST_MAX_MS)) begin
              d.rst_len = q.rst_len + 12'h001;
            end
          end else begin
            d.rst_len = '0;
          end
          if (!en) begin
            d.out = 1'b0;
          end else if (!mm) begin
            if (reset_monitor_input) begin
              d.out = 1'b1;
            end
          end else if (q.rst_prev && !reset_monitor_input &&
                       (q.rst_len >= SRL_RST_MIN_MS) &&
                       (q.rst_len <= SRL_RST_MAX_MS)) begin
            d.out = 1'b1;
          end
        end
      end

      SRL_ST_FAULT: begin
        d.fault = 1'b1;
        d.out = 1'b0;
        d.green = 1'b0;
        d.tp = 1'b0;
        d.red = q.ph;
        d.ind_a = 1'b0;
        d.ind_t = 1'b0;
        d.ind_l = 1'b0;
      end

      default: begin
        d.st = SRL_ST_FAULT;
      end
    endcase
    d.cfgm = (d.st == SRL_ST_CFG_WAIT) || (d.st == SRL_ST_CFG);
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= SRL_ST_BOOT;
    end else begin
      q <= d;
    end
  end

  assign safety_out_q = q.out;
  assign power_fault_red_q = q.red;
  assign power_fault_green_q = q.green;
  assign ind_input_a_q = q.ind_a;
  assign ind_cfg_term_q = q.ind_t;
  assign ind_link_q = q.ind_l;
  assign test_pulse_q = q.tp;
  assign nvm_erase_q = q.erase;
  assign nvm_write_q = q.write;
  assign nvm_wr_cfg_q = q.cfg;
  assign nvm_wr_time_q = q.tim_pos;
  assign nvm_wr_long_q = q.long_r;
  assign config_mode_q = q.cfgm;
  assign perm_fault_q = q.fault;

endmodule

// *** sim/srl_top_monitor.sv ***
`timescale 1ns/1ps
module srl_top_monitor
  import srl_pkg::*;
#(
  parameter int MS_CYCLES = SRL_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] variant,
  input wire logic [3:0] logic_sw,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic link_safety_input,
  input wire logic safety_out_q,
  input wire logic power_fault_green_q,
  input wire logic test_pulse_q,
  input wire logic nvm_erase_q,
  input wire logic nvm_write_q,
  input wire logic [3:0] nvm_wr_cfg_q,
  input wire logic config_mode_q,
  input wire logic perm_fault_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  erase_pulse_a: assert property (nvm_erase_q |=> !nvm_erase_q)
    else $error("erase pulse longer than one cycle");
  erase_entry_a: assert property ($rose(config_mode_q) |-> nvm_erase_q)
    else $error("configuration entered without erase");
  write_cfg_a: assert property (nvm_write_q |-> config_mode_q && !nvm_erase_q)
    else $error("store written outside configuration");
  write_data_a: assert property (nvm_write_q && variant == 2'h1 |-> nvm_wr_cfg_q == logic_sw)
    else $error("written setting differs from switch");
  cfg_off_a: assert property (config_mode_q |-> !safety_out_q && !power_fault_green_q)
    else $error("outputs active in configuration");
  fault_hold_a: assert property (perm_fault_q |=> perm_fault_q)
    else $error("permanent fault cleared without reset");
  fault_dark_a: assert property (perm_fault_q |-> !power_fault_green_q && !safety_out_q)
    else $error("fault with green or outputs on");
  pulse_cfg_a: assert property (test_pulse_q |-> config_mode_q ##1 !test_pulse_q)
    else $error("test pulse outside configuration or too long");
  and_drop_a: assert property (!config_mode_q && variant == 2'h1 && logic_sw == 4'h8 &&
    !(safety_input_a && safety_input_b && link_safety_input) |=> !safety_out_q)
    else $error("all-and function left outputs on");
  or_drop_a: assert property (!config_mode_q && variant == 2'h1 && logic_sw == 4'h5 &&
    !(safety_input_a || safety_input_b || link_safety_input) |=> !safety_out_q)
    else $error("all-or function left outputs on");
  boot_quiet_a: assert property ($rose(rst_b) |-> !safety_out_q ##1 !safety_out_q)
    else $error("outputs on before power-up checks");
  cover property ($rose(config_mode_q));
  cover property (nvm_write_q);
  cover property ($rose(perm_fault_q));
  cover property ($rose(safety_out_q));
endmodule

bind srl_top srl_top_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .variant(variant),
  .logic_sw(logic_sw),
  .safety_input_a(safety_input_a),
  .safety_input_b(safety_input_b),
  .link_safety_input(link_safety_input),
  .safety_out_q(safety_out_q),
  .power_fault_green_q(power_fault_green_q),
  .test_pulse_q(test_pulse_q),
  .nvm_erase_q(nvm_erase_q),
  .nvm_write_q(nvm_write_q),
  .nvm_wr_cfg_q(nvm_wr_cfg_q),
  .config_mode_q(config_mode_q),
  .perm_fault_q(perm_fault_q)
);

// *** sim/srl_operator.sv ***
`timescale 1ns/1ps
module srl_operator (
  input wire logic core_clk,
  input wire logic nvm_erase_q,
  input wire logic nvm_write_q,
  input wire logic [3:0] nvm_wr_cfg_q,
  input wire logic [3:0] nvm_wr_time_q,
  input wire logic nvm_wr_long_q,
  output logic rst_b,
  output logic [1:0] variant,
  output logic [3:0] sw,
  output logic [3:0] time_sw,
  output logic a_to_b,
  output logic nvm_valid,
  output logic [3:0] nvm_cfg_pos,
  output logic [3:0] nvm_time_pos,
  output logic nvm_long_range
);
  initial begin
    rst_b = 1'b0;
    variant = 2'h0;
    sw = 4'h0;
    time_sw = 4'h1;
    a_to_b = 1'b0;
    nvm_valid = 1'b0;
    nvm_cfg_pos = 4'h0;
    nvm_time_pos = 4'h0;
    nvm_long_range = 1'b0;
  end
  // Store keeps its content across power cycles
  always @(posedge core_clk) begin
    if (nvm_erase_q) begin
      nvm_valid <= 1'b0;
    end else if (nvm_write_q) begin
      nvm_valid <= 1'b1;
      nvm_cfg_pos <= nvm_wr_cfg_q;
      nvm_time_pos <= nvm_wr_time_q;
      nvm_long_range <= nvm_wr_long_q;
    end
  end
  // Switches move only with power off or inside configuration
  task automatic power_up(input logic [1:0] v, input logic [3:0] s, input logic [3:0] t,
                          input logic r);
    rst_b = 1'b0;
    repeat (10) @(posedge core_clk);
    #5;
    variant = v;
    sw = s;
    time_sw = t;
    a_to_b = r;
    @(posedge core_clk);
    #5;
    rst_b = 1'b1;
  endtask
  task automatic turn(input logic [3:0] s, input logic [3:0] t);
    @(posedge core_clk);
    #5;
    sw = s;
    time_sw = t;
  endtask
endmodule

// *** sim/srl_top_tb.sv ***
`timescale 1ns/1ps
module srl_top_tb;
  import srl_pkg::*;
  localparam int MSC = 2;
  logic core_clk = 1'b0;
  logic rst_b, a_to_b, a, b, l, rm, cc, nvm_valid, nvm_long, out, red, green, ind_a, ind_t;
  logic ind_l, tp, ers, wr, wr_long, cfg, flt, jg, prev;
  logic [1:0] variant;
  logic [3:0] sw, tsw, nvm_cfg, nvm_time, wr_cfg, wr_time;
  int num_errors = 0;
  int checks = 0;
  int n;
  always #25 core_clk = ~core_clk;
  srl_operator op (.core_clk(core_clk), .nvm_erase_q(ers), .nvm_write_q(wr),
    .nvm_wr_cfg_q(wr_cfg), .nvm_wr_time_q(wr_time), .nvm_wr_long_q(wr_long), .rst_b(rst_b),
    .variant(variant), .sw(sw), .time_sw(tsw), .a_to_b(a_to_b), .nvm_valid(nvm_valid),
    .nvm_cfg_pos(nvm_cfg), .nvm_time_pos(nvm_time), .nvm_long_range(nvm_long));
  srl_top #(.MS_CYCLES(MSC)) i_srl_top (.core_clk(core_clk), .rst_b(rst_b),
    .variant(variant), .reset_sw(sw), .logic_sw(sw), .range_sw(sw), .time_sw(tsw),
    .timing_config_terminal_a_to_b(a_to_b), .timing_config_terminal_a_to_24v(jg),
    .safety_input_a(a), .safety_input_b(b), .link_safety_input(l),
    .reset_monitor_input(rm), .circuit_check_ok(cc), .nvm_valid(nvm_valid),
    .nvm_cfg_pos(nvm_cfg), .nvm_time_pos(nvm_time), .nvm_long_range(nvm_long),
    .safety_out_q(out), .power_fault_red_q(red), .power_fault_green_q(green),
    .ind_input_a_q(ind_a), .ind_cfg_term_q(ind_t), .ind_link_q(ind_l), .test_pulse_q(tp),
    .nvm_erase_q(ers), .nvm_write_q(wr), .nvm_wr_cfg_q(wr_cfg), .nvm_wr_time_q(wr_time),
    .nvm_wr_long_q(wr_long), .config_mode_q(cfg), .perm_fault_q(flt));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic ms(input int k);
    repeat (k * MSC) @(posedge core_clk);
    #5;
  endtask
  task automatic wait_hi(ref logic s, input int k);
    for (int i = 0; i < k && s !== 1'b1; i++) begin
      @(posedge core_clk);
      #5;
    end
  endtask
  function automatic logic en_f(input logic [3:0] p, input logic x, y, z);
    case ((p - 4'h1) % 4)
      0: return (x | y) | z;
      1: return (x & y) | z;
      2: return (x | y) & z;
      default: return (x & y) & z;
    endcase
  endfunction
  task automatic configure(input logic [1:0] v, input logic [3:0] s, input logic [3:0] t);
    a = 1'b1;
    b = 1'b1;
    l = 1'b1;
    op.power_up(v, 4'h0, 4'h1, 1'b0);
    ms(120);
    op.turn(s, t);
    wait_hi(wr, 8);
    check("write", wr, 1'b1);
    check("write data", wr_cfg, s);
    ms(1);
    check("change flash", red, 1'b1);
  endtask
  task automatic pulse(input int k, input logic exp);
    rm = 1'b1;
    ms(k);
    rm = 1'b0;
    ms(5);
    check("monitored reset", out, exp);
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    n = $urandom(56);
    {a, b, l, rm, cc, jg} = 6'h02;
    for (int v = 0; v < 3; v++) begin
      op.power_up(v[1:0], 4'h0, 4'h1, 1'b0);
      repeat (2) @(posedge core_clk);
      #5;
      check("erase", ers, 1'b1);
      check("config mode", cfg, 1'b1);
    end
    configure(2'h1, 4'h3, 4'h1);
    wait_hi(ind_a, 2600 * MSC);
    n = 0;
    while (ind_a === 1'b1 && n < 2000 * MSC) begin
      n++;
      @(posedge core_clk);
      #5;
    end
    check("flash length", n, 500 * MSC);
    n = 1;
    // Window ends before the next burst after the pause
    for (int i = 0; i < 3000 * MSC; i++) begin
      prev = ind_a;
      @(posedge core_clk);
      #5;
      if (ind_a === 1'b1 && prev !== 1'b1) n++;
    end
    check("flash count", n, 3);
    op.power_up(2'h1, 4'h3, 4'h1, 1'b0);
    {a, b, l} = 3'h5;
    ms(5);
    check("green", green, 1'b1);
    pulse(100, 1'b0);
    pulse(500, 1'b1);
    a = 1'b0;
    ms(2);
    check("drop", out, 1'b0);
    a = 1'b1;
    pulse(3500, 1'b0);
    for (logic [3:0] p = 4'h5; p <= 4'h8; p++) begin
      configure(2'h1, p, 4'h1);
      op.power_up(2'h1, p, 4'h1, 1'b0);
      rm = 1'b1;
      for (int i = 0; i < 30; i++) begin
        {a, b, l} = 3'($urandom);
        repeat (4) @(posedge core_clk);
        #5;
        check("function", out, en_f(p, a, b, l));
      end
    end
    op.power_up(2'h1, 4'h2, 4'h1, 1'b0);
    wait_hi(flt, 8);
    check("mismatch fault", flt, 1'b1);
    check("mismatch green", green, 1'b0);
    configure(2'h0, 4'h2, 4'h1);
    op.power_up(2'h0, 4'h2, 4'h1, 1'b0);
    {a, b, l, rm} = 4'hF;
    ms(3);
    check("single auto", out, 1'b1);
    configure(2'h2, 4'h1, 4'h2);
    wait_hi(ind_l, 2600 * MSC);
    check("time flash", ind_l, 1'b1);
    for (int r = 0; r < 2; r++) begin
      op.power_up(2'h2, 4'h1, 4'h2, r[0]);
      {a, b, l, rm} = 4'hF;
      wait_hi(out, 100 * MSC);
      check("timed on", out, 1'b1);
      {a, b, l} = 3'h0;
      if (r == 1) begin
        ms(50);
        {a, b, l} = 3'h7;
        ms(300);
        check("retrigger", out, 1'b1);
      end else begin
        ms(150);
        check("delay run", out, 1'b1);
        ms(60);
        check("delay end", out, 1'b0);
      end
      check("terminal ind", ind_t, r[0]);
    end
    for (int k = 0; k < 2; k++) begin
      configure(2'h2, k ? 4'h8 : 4'h5, 4'h1);
      op.power_up(2'h2, k ? 4'h8 : 4'h5, 4'h1, 1'b0);
      jg = k[0];
      ms(250);
      check("delay start", out, k[0]);
      ms(60);
      check("delay pass", out, 1'b1);
      jg = 1'b0;
      ms(1);
      check("jog stop", out, !k[0]);
    end
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end
endmodule
